// File: verilog/cfg_target.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfg_target_map.svh"
// Contract
// - Fresh part answers at factory address.
// - After programming, boot at stored address.
// - Slave address register returns current address.
// - Part identity reads as two bytes: the low register, then the high one.
// - Product line register reads one byte.
// - Offset plus 128 bytes fill volatile registers.
// - Restart reloads stored copy into volatile.
// - Save only when CRC over 126 matches.
// - Status FD on write fail, FE CRC.
// - Opcode FF performs soft restart.
module cfg_target (
    input  wire logic                       i_clk,
    input  wire logic                       i_reset,
    input  wire logic                       i_link_clk,
    input  wire logic                       i_wr_valid,
    input  wire logic                       i_wr_start,
    input  wire logic [7:0]                 i_wr_byte,
    input  wire logic                       i_rd_req,
    input  wire logic                       i_nvm_fail,
    input  wire cfg_target_pkg::byte_t      i_part_id_low,
    input  wire cfg_target_pkg::byte_t      i_part_id_high,
    input  wire cfg_target_pkg::byte_t      i_product_line,
    output logic                            o_rd_valid,
    output cfg_target_pkg::byte_t           o_rd_byte,
    output cfg_target_pkg::slave_addr_t     o_slave_addr,
    output cfg_target_pkg::byte_t           o_cmd_status,
    output logic                            o_busy
);
    import cfg_target_pkg::*;

    // Link side: bytes arrive on the link clock; a toggle carries each event.
    logic [7:0] link_byte;
    logic       link_first;
    logic       link_tgl;
    logic       link_rd_tgl;
    always_ff @(posedge i_link_clk or posedge i_reset) begin
        if (i_reset) begin
            link_byte   <= 8'h00;
            link_first  <= 1'b0;
            link_tgl    <= 1'b0;
            link_rd_tgl <= 1'b0;
        end else begin
            if (i_wr_valid) begin
                link_byte  <= i_wr_byte;
                link_first <= i_wr_start;
                link_tgl   <= ~link_tgl;
            end
            if (i_rd_req) begin
                link_rd_tgl <= ~link_rd_tgl;
            end
        end
    end

    // Two-flop synchronisers, then an edge detector on the third stage.
    logic [2:0] wsync;
    logic [2:0] rsync;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wsync <= 3'b000;
            rsync <= 3'b000;
        end else begin
            wsync <= {wsync[1:0], link_tgl};
            rsync <= {rsync[1:0], link_rd_tgl};
        end
    end
    logic wr_evt;
    logic rd_evt;
    assign wr_evt = wsync[2] ^ wsync[1];
    assign rd_evt = rsync[2] ^ rsync[1];

    // Byte and flag stay stable for several link cycles after the toggle.
    logic [7:0] wbyte;
    logic       wfirst;
    assign wbyte  = link_byte;
    assign wfirst = link_first;

    // Register pointer: first byte of a write sets it, further bytes store.
    logic [7:0] ptr;
    logic       have_ptr;
    seq_state_t state;
    logic [7:0] seq_idx;
    logic [15:0] crc;
    logic [15:0] stored_crc;
    logic [7:0]  mem_rdata;
    logic [6:0]  nvm_addr_q;
    logic        in_cfg;
    assign in_cfg = (ptr <= `REG_CONFIG_LAST);

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ptr      <= 8'h00;
            have_ptr <= 1'b0;
        end else if (wr_evt) begin
            if (wfirst) begin
                ptr      <= wbyte;
                have_ptr <= 1'b1;
            end else begin
                ptr <= ptr + 8'h01; // Auto-increment through a 129-byte packet.
            end
        end else if (rd_evt) begin
            ptr <= ptr + 8'h01;
        end
    end

    // Volatile configuration registers, loaded by the host or by reload.
    logic       vol_we;
    logic [6:0] vol_waddr;
    logic [7:0] vol_wdata;
    logic [7:0] vol_rdata;
    logic [6:0] vol_raddr;
    logic       host_wr;
    assign host_wr = wr_evt && !wfirst && have_ptr && in_cfg && (state == ST_IDLE);
    always_comb begin
        vol_we    = 1'b0;
        vol_waddr = ptr[6:0];
        vol_wdata = wbyte;
        if (host_wr) begin
            vol_we = 1'b1; // Configuration bytes land in volatile registers.
        end else if (state == ST_LOAD && seq_idx != 8'h00) begin
            vol_we    = 1'b1; // Stored copy reloaded into volatile registers.
            vol_waddr = nvm_addr_q;
            vol_wdata = mem_rdata;
        end
    end
    // Host reads follow the pointer; the sequencer walks its own index.
    // The read data are registered, so they trail the address by one cycle.
    assign vol_raddr = (state == ST_IDLE) ? ptr[6:0] : seq_idx[6:0];
    cfg_byte_mem u_vol (
        .i_clk   (i_clk),
        .i_we    (vol_we),
        .i_waddr (vol_waddr),
        .i_wdata (vol_wdata),
        .i_raddr (vol_raddr),
        .o_rdata (vol_rdata)
    );

    // Nonvolatile copy; written during save, read during reload.
    // Its write address trails the index by one step, as the volatile read data do.
    logic       nvm_we;
    logic [6:0] nvm_addr;
    assign nvm_we   = (state == ST_SAVE) && (seq_idx != 8'h00) && !i_nvm_fail;
    assign nvm_addr = seq_idx[6:0];
    cfg_byte_mem u_nvm (
        .i_clk   (i_clk),
        .i_we    (nvm_we),
        .i_waddr (nvm_addr_q),
        .i_wdata (vol_rdata),
        .i_raddr (nvm_addr),
        .o_rdata (mem_rdata)
    );

    // CRC step over one byte.
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c ^ {d, 8'h00};
        for (int b = 0; b < 8; b++) begin
            r = r[15] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    // Command sequencer: CRC check, save, reload.
    logic cmd_wr;
    logic save_failed;
    assign cmd_wr = wr_evt && !wfirst && (ptr == `REG_COMMAND) && (state == ST_IDLE);
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state        <= ST_LOAD;
            seq_idx      <= 8'h00;
            crc          <= `CRC_INIT;
            stored_crc   <= 16'h0000;
            o_cmd_status <= `STATUS_OK;
            save_failed  <= 1'b0;
            nvm_addr_q   <= 7'h00;
        end else begin
            nvm_addr_q <= seq_idx[6:0]; // Index of the byte now on the read ports.
            case (state)
                ST_IDLE: begin
                    seq_idx <= 8'h00;
                    if (cmd_wr && wbyte == `OP_SAVE_CHECK_CRC) begin
                        state <= ST_CRC;
                        crc   <= `CRC_INIT;
                    end else if (cmd_wr && wbyte == `OP_SOFT_RESTART) begin
                        state <= ST_LOAD; // Soft restart reloads stored configuration.
                    end
                end
                ST_CRC: begin
                    // Read data lag one step, so each step sees the byte before its index.
                    if (seq_idx != 8'h00 && seq_idx <= `CRC_SPAN) begin
                        crc <= crc_step(crc, vol_rdata); // CRC over 126 bytes.
                    end else if (seq_idx == `REG_CRC_LO) begin
                        stored_crc[15:8] <= vol_rdata;
                    end else if (seq_idx == `CFG_WORDS) begin
                        stored_crc[7:0] <= vol_rdata;
                    end
                    if (seq_idx == `CFG_WORDS) begin
                        seq_idx <= 8'h00;
                        if ({stored_crc[15:8], vol_rdata} == crc) begin
                            state       <= ST_SAVE;
                            save_failed <= 1'b0;
                        end else begin
                            state        <= ST_IDLE;
                            o_cmd_status <= `STATUS_CRC_ERROR;
                        end
                    end else begin
                        seq_idx <= seq_idx + 8'h01;
                    end
                end
                ST_SAVE: begin
                    if (i_nvm_fail) begin
                        save_failed <= 1'b1;
                    end
                    if (seq_idx == `CFG_WORDS) begin
                        state        <= ST_IDLE;
                        o_cmd_status <= (save_failed || i_nvm_fail) ?
                                        `STATUS_WRITE_FAIL : `STATUS_OK;
                    end else begin
                        seq_idx <= seq_idx + 8'h01;
                    end
                end
                ST_LOAD: begin
                    if (seq_idx == `CFG_WORDS) begin
                        state <= ST_IDLE;
                    end else begin
                        seq_idx <= seq_idx + 8'h01;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Slave address: factory value until a reload brings a stored one.
    logic addr_loaded;
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_slave_addr <= `FACTORY_ADDR;
            addr_loaded  <= 1'b0;
        end else if (vol_we && !host_wr && {1'b0, vol_waddr} == `REG_SLAVE_ADDR &&
                     (vol_wdata != 8'h00 || addr_loaded)) begin
            o_slave_addr <= vol_wdata[6:0]; // Boot address from stored image.
            addr_loaded  <= 1'b1;
        end
    end

    // Read data selected by pointer and registered toward the link side.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd_byte  <= 8'h00;
            o_rd_valid <= 1'b0;
            o_busy     <= 1'b1;
        end else begin
            o_busy     <= (state != ST_IDLE);
            o_rd_valid <= rd_evt;
            if (rd_evt) begin
                case (ptr)
                    `REG_SLAVE_ADDR:   o_rd_byte <= {1'b0, o_slave_addr};
                    `REG_PART_ID_LOW:  o_rd_byte <= i_part_id_low;
                    `REG_PART_ID_HIGH: o_rd_byte <= i_part_id_high;
                    `REG_PRODUCT_LINE: o_rd_byte <= i_product_line;
                    `REG_CMD_STATUS:   o_rd_byte <= o_cmd_status;
                    default:           o_rd_byte <= in_cfg ? vol_rdata : 8'h00;
                endcase
            end
        end
    end
endmodule : cfg_target
`default_nettype wire

// File: verilog/cfg_target_map.svh
`ifndef CFG_TARGET_MAP_SVH
`define CFG_TARGET_MAP_SVH
`define FACTORY_ADDR      7'h37
`define REG_CONFIG_BASE   8'h00
`define REG_CONFIG_LAST   8'h7F
`define REG_CRC_HI        8'h7E
`define REG_CRC_LO        8'h7F
`define REG_SLAVE_ADDR    8'h51
`define REG_PRODUCT_LINE  8'h8F
`define REG_PART_ID_LOW   8'h90
`define REG_PART_ID_HIGH  8'h91
`define REG_COMMAND       8'h86
`define REG_CMD_STATUS    8'h89
`define OP_SAVE_CHECK_CRC 8'h02
`define OP_SOFT_RESTART   8'hFF
`define STATUS_OK         8'h00
`define STATUS_WRITE_FAIL 8'hFD
`define STATUS_CRC_ERROR  8'hFE
`define CRC_SPAN          8'h7E
`define CRC_INIT          16'hFFFF
`define CRC_POLY          16'h1021
// Final sequencer step: one past the last byte, to cover the registered read lag.
`define CFG_WORDS         8'h80
`endif

// File: verilog/cfg_target_pkg.sv
`default_nettype none
package cfg_target_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [6:0] slave_addr_t;
    typedef enum {ST_IDLE, ST_CRC, ST_SAVE, ST_LOAD} seq_state_t;
endpackage : cfg_target_pkg
`default_nettype wire

// File: verilog/cfg_byte_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Small byte memory with a registered read port.
module cfg_byte_mem (
    input  wire logic       i_clk,
    input  wire logic       i_we,
    input  wire logic [6:0] i_waddr,
    input  wire logic [7:0] i_wdata,
    input  wire logic [6:0] i_raddr,
    output logic      [7:0] o_rdata
);
    logic [7:0] mem [0:127];

    // Write and registered read in one process.
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule : cfg_byte_mem
`default_nettype wire

// File: testbench/cfg_target_props.sv
`timescale 1ns/1ps
`default_nettype none
// Checks the target's outputs against reset, read and command behaviour.
module cfg_target_props (
    input wire logic                        i_clk,
    input wire logic                        i_reset,
    input wire logic                        o_rd_valid,
    input wire cfg_target_pkg::byte_t       o_rd_byte,
    input wire cfg_target_pkg::slave_addr_t o_slave_addr,
    input wire cfg_target_pkg::byte_t       o_cmd_status,
    input wire logic                        o_busy
);
    import cfg_target_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Address and status may only move while a load, CRC check or save runs.
    a_factory_addr: assert property (disable iff (1'b0)
        i_reset ##1 i_reset |-> o_slave_addr == 7'h37) else $error("addr not factory");
    a_addr_on_load: assert property (
        !$stable(o_slave_addr) |-> $past(o_busy)) else $error("addr moved idle");
    a_status_codes: assert property (
        o_cmd_status inside {8'h00, 8'hFD, 8'hFE}) else $error("bad status code");
    a_status_on_save: assert property (
        !$stable(o_cmd_status) |-> $past(o_busy)) else $error("status moved idle");
    // Read data is a one-cycle strobe over a held byte.
    a_read_pulse: assert property (
        o_rd_valid |=> !o_rd_valid) else $error("read strobe long");
    a_read_hold: assert property (
        !o_rd_valid |-> $stable(o_rd_byte)) else $error("read byte moved");
    // Loads and saves finish in bounded time.
    a_boot_reload: assert property (
        $fell(i_reset) |-> o_busy ##[1:400] !o_busy) else $error("boot load hung");
    a_busy_bounded: assert property (
        $rose(o_busy) |-> o_busy[*8] ##[1:1000] !o_busy) else $error("busy wrong");
    c_crc_error: cover property ($fell(o_busy) && o_cmd_status == 8'hFE);
    c_new_addr: cover property (o_slave_addr != 7'h37);
    c_read: cover property (o_rd_valid);
endmodule : cfg_target_props
bind cfg_target cfg_target_props i_props (.i_clk(i_clk), .i_reset(i_reset),
    .o_rd_valid(o_rd_valid), .o_rd_byte(o_rd_byte), .o_slave_addr(o_slave_addr),
    .o_cmd_status(o_cmd_status), .o_busy(o_busy));
`default_nettype wire

// File: testbench/cfg_programmer_model.sv
`timescale 1ns/1ps
`default_nettype none
// Programmer on the link side: sends packet bytes and fetches read bytes.
module cfg_programmer_model (
    input  wire logic       i_link_clk,
    input  wire logic       i_clk,
    input  wire logic       i_rd_valid,
    input  wire logic [7:0] i_rd_byte,
    output logic            o_wr_valid,
    output logic            o_wr_start,
    output logic [7:0]      o_wr_byte,
    output logic            o_rd_req
);
    // Idle levels at time zero; the link stays quiet outside transfers.
    initial begin
        o_wr_valid = 1'b0;
        o_wr_start = 1'b0;
        o_wr_byte  = 8'h00;
        o_rd_req   = 1'b0;
    end
    // Pointer byte opens a packet; data is inverted once released.
    task automatic put(input logic start, input logic [7:0] b);
        @(posedge i_link_clk);
        o_wr_valid <= 1'b1;
        o_wr_start <= start;
        o_wr_byte  <= b;
        @(posedge i_link_clk);
        o_wr_valid <= 1'b0;
        o_wr_start <= 1'b0;
        o_wr_byte  <= ~b;
        repeat (3) @(posedge i_link_clk);
    endtask : put
    // One read byte, waited for a bounded time; unknown if none came.
    task automatic get(output logic [7:0] b);
        int n;
        b = 8'hxx;
        @(posedge i_link_clk);
        o_rd_req <= 1'b1;
        @(posedge i_link_clk);
        o_rd_req <= 1'b0;
        for (n = 0; n < 40; n++) begin // Bounded wait for the answer.
            @(negedge i_clk);
            if (i_rd_valid === 1'b1) begin
                b = i_rd_byte;
                n = 40;
            end
        end
        repeat (2) @(posedge i_link_clk);
    endtask : get
endmodule : cfg_programmer_model
`default_nettype wire

// File: testbench/cfg_target_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cfg_target_tb;
    import cfg_target_pkg::*;
    logic        clk, rst, lclk, nvm_fail, wr_valid, wr_start, rd_req, rd_valid, busy;
    logic [7:0]  wr_byte;
    byte_t       id_low, id_high, line_id, rd_byte, status;
    slave_addr_t addr;
    byte_t       img [128];
    byte_t       nvm [128];
    int          num_errors, checks_done, cycles;
    // Clocks of the two domains.
    always #50 clk = ~clk;
    always #62.5 lclk = ~lclk;
    cfg_target i_dut (.i_clk(clk), .i_reset(rst), .i_link_clk(lclk), .i_wr_valid(wr_valid),
        .i_wr_start(wr_start), .i_wr_byte(wr_byte), .i_rd_req(rd_req), .i_nvm_fail(nvm_fail),
        .i_part_id_low(id_low), .i_part_id_high(id_high), .i_product_line(line_id),
        .o_rd_valid(rd_valid), .o_rd_byte(rd_byte), .o_slave_addr(addr),
        .o_cmd_status(status), .o_busy(busy));
    cfg_programmer_model i_prog (.i_link_clk(lclk), .i_clk(clk), .i_rd_valid(rd_valid),
        .i_rd_byte(rd_byte), .o_wr_valid(wr_valid), .o_wr_start(wr_start),
        .o_wr_byte(wr_byte), .o_rd_req(rd_req));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Cuts a hung run short.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Lets a started load or save begin, then waits for it to end.
    task automatic wait_idle;
        int n;
        for (n = 0; n < 20 && busy !== 1'b1; n++) @(negedge clk);
        for (n = 0; n < 2000 && busy !== 1'b0; n++) @(negedge clk);
        check({7'h00, busy}, 8'h00);
    endtask : wait_idle
    task automatic verify;
        byte_t b;
        check({1'b0, addr}, nvm[8'h51]);
        i_prog.put(1'b1, 8'h00);
        foreach (nvm[i]) begin
            i_prog.get(b);
            check(b, nvm[i]);
        end
    endtask : verify
    task automatic t_ident;
        byte_t b;
        check({1'b0, addr}, 8'h37);
        i_prog.put(1'b1, 8'h90);
        i_prog.get(b);
        check(b, id_low);
        i_prog.get(b);
        check(b, id_high);
        i_prog.put(1'b1, 8'h8F);
        i_prog.get(b);
        check(b, line_id);
        i_prog.put(1'b1, 8'h51);
        i_prog.get(b);
        check(b, 8'h37);
    endtask : t_ident
    task automatic t_commit(input byte_t a, input logic bad, input logic fail, input byte_t st);
        byte_t       b;
        logic [15:0] crc;
        for (int i = 0; i < 128; i++) img[i] = 8'(i * 7) + a;
        img[8'h51] = a;
        crc = 16'hFFFF;
        for (int i = 0; i < 126; i++) begin
            crc = crc ^ {img[i], 8'h00};
            repeat (8) crc = crc[15] ? {crc[14:0], 1'b0} ^ 16'h1021 : {crc[14:0], 1'b0};
        end
        img[126] = crc[15:8];
        img[127] = crc[7:0] ^ {7'h00, bad};
        @(posedge clk);
        nvm_fail <= fail;
        i_prog.put(1'b1, 8'h00);
        foreach (img[i]) i_prog.put(1'b0, img[i]);
        i_prog.put(1'b1, 8'h86);
        i_prog.put(1'b0, 8'h02);
        wait_idle();
        check(status, st);
        i_prog.put(1'b1, 8'h89);
        i_prog.get(b);
        check(b, st);
        if (st == 8'h00) nvm = img;
        i_prog.put(1'b1, 8'h86);
        i_prog.put(1'b0, 8'hFF);
        wait_idle();
        verify();
    endtask : t_commit
    // Main sequence, ending with a reset in mid-run.
    initial begin
        clk = 1'b0;
        lclk = 1'b0;
        rst = 1'b1;
        nvm_fail = 1'b0;
        // Identity values are arbitrary.
        id_low = 8'hA5;
        id_high = 8'h3C;
        line_id = 8'h9E;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        foreach (nvm[i]) nvm[i] = 8'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wait_idle();
        t_ident();
        t_commit(8'h2A, 1'b0, 1'b0, 8'h00);
        t_commit(8'h55, 1'b1, 1'b0, 8'hFE);
        t_commit(8'h66, 1'b0, 1'b1, 8'hFD);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wait_idle();
        verify();
        wrap_up();
    end
endmodule : cfg_target_tb
`default_nettype wire
